/* File: src/ccm_pkg.sv */
// package: constants and types of the mode, interrupt and clock-out block
package ccm_pkg;
  // register addresses and address decode
  localparam logic [7:0] ADDR_IRQ_EN = 8'h2B;
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h2C;
  localparam logic [3:0] ADDR_LO_STATUS = 4'hE;
  localparam logic [3:0] ADDR_LO_CONTROL = 4'hF;
  // reset values
  localparam logic [7:0] RST_IRQ_EN = 8'h00;
  localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'hE7;
  // interrupt enable / flag bit positions
  localparam int BIT_MSG_ERR = 7;
  localparam int BIT_WAKE = 6;
  localparam int BIT_ERR_CHG = 5;
  localparam int BIT_TX2 = 4;
  localparam int BIT_TX1 = 3;
  localparam int BIT_TX0 = 2;
  localparam int BIT_RX1 = 1;
  localparam int BIT_RX0 = 0;
  // main_control fields
  localparam int CTL_REQ_LSB = 5;
  localparam int CTL_CLOCK_OUTPUT_EN = 2;
  localparam int CTL_DIV_LSB = 0;
  // main_status fields
  localparam int STS_MODE_LSB = 5;
  localparam int STS_IRQ_SOURCE_CODE_LSB = 1;
  // mode codes, shared by request and status fields
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_SLEEP = 3'h1;
  localparam logic [2:0] MODE_LOOPBACK = 3'h2;
  localparam logic [2:0] MODE_LISTEN = 3'h3;
  localparam logic [2:0] MODE_CONFIG = 3'h4;
  // interrupt source codes, lower is more urgent
  localparam logic [2:0] IRQ_SOURCE_CODE_NONE = 3'h0;
  localparam logic [2:0] IRQ_SOURCE_CODE_ERR = 3'h1;
  localparam logic [2:0] IRQ_SOURCE_CODE_WAKE = 3'h2;
  localparam logic [2:0] IRQ_SOURCE_CODE_TX0 = 3'h3;
  localparam logic [2:0] IRQ_SOURCE_CODE_TX1 = 3'h4;
  localparam logic [2:0] IRQ_SOURCE_CODE_TX2 = 3'h5;
  localparam logic [2:0] IRQ_SOURCE_CODE_RX0 = 3'h6;
  localparam logic [2:0] IRQ_SOURCE_CODE_RX1 = 3'h7;
  // timing counts in oscillator cycles, except the sleep count, which is in clock-output periods
  localparam int OST_CYCLES = 128;
  localparam int SLEEP_CLK_PERIODS = 16;
  localparam int WAKE_FILT_CYCLES = 8;
  localparam int IDLE_CYCLES = 11;
  // clock output divider codes
  localparam logic [1:0] DIV_BY_8 = 2'h3;

  typedef enum logic [6:0] {
    ST_CONFIG = 7'h01,
    ST_NORMAL = 7'h02,
    ST_DRAIN = 7'h04,
    ST_SLEEP = 7'h08,
    ST_WAKE = 7'h10,
    ST_LISTEN = 7'h20,
    ST_LOOP = 7'h40
  } ccm_state_e;

  // hardware interrupt events from the protocol engine, one-cycle pulses
  typedef struct packed {
    logic msg_error;
    logic err_change;
    logic tx_buf2_empty;
    logic tx_buf1_empty;
    logic tx_buf0_empty;
    logic rx_buf1_full;
    logic rx_buf0_full;
  } ccm_evt_s;

  // mode controls handed to the protocol engine
  typedef struct packed {
    logic tx_allowed;
    logic listen_only;
    logic loopback;
    logic err_cnt_clear;
    logic rx_discard;
  } ccm_mode_ctl_s;
endpackage

/* File: src/ccm_divided_clock_output.sv */
// divided clock output with setting changes taken at the end of a high phase
`timescale 1ns/10ps
`default_nettype none
module ccm_divided_clock_output (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic [1:0] div_i,
  input wire logic stop_i,
  output logic clk_o,
  output logic clk_oe_o,
  output logic period_o
);
  import ccm_pkg::*;

  logic [2:0] ph_cnt_reg;
  logic phase_reg;
  logic cur_en_reg;
  logic [1:0] cur_div_reg;
  logic stopped_reg;
  logic [2:0] ph_last;
  logic boundary;

  // each phase lasts 2^div cycles; boundary is the end of a high phase
  // period_o marks each point where a high phase would start
  assign ph_last = 3'((4'h1 << cur_div_reg) - 4'h1);
  assign boundary = (ph_cnt_reg == ph_last) && phase_reg;

  ///////////////////////////////////////////////////////////////////////
  // settings are taken only at the end of a high phase, so no phase is cut short
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_cnt_reg <= 3'h0;
      phase_reg <= 1'b0;
      cur_en_reg <= 1'b1;
      cur_div_reg <= DIV_BY_8;
      stopped_reg <= 1'b0;
      period_o <= 1'b0;
    end else if (stopped_reg) begin
      stopped_reg <= stop_i;
      period_o <= 1'b0;
    end else if (ph_cnt_reg == ph_last) begin
      ph_cnt_reg <= 3'h0;
      // a stop lands where a low phase ends, so the pin just stays low
      phase_reg <= ~phase_reg & ~stop_i;
      period_o <= ~phase_reg;
      if (boundary) begin
        cur_en_reg <= en_i;
        cur_div_reg <= div_i;
      end else begin
        stopped_reg <= stop_i;
      end
    end else begin
      ph_cnt_reg <= ph_cnt_reg + 3'h1;
      period_o <= 1'b0;
    end
  end

  // pin: high-z while disabled, low while stopped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_o <= 1'b0;
      clk_oe_o <= 1'b0;
    end else begin
      clk_o <= phase_reg & cur_en_reg & ~stopped_reg;
      clk_oe_o <= cur_en_reg;
    end
  end
endmodule
`default_nettype wire

/* File: src/ccm_top.sv */
// mode, interrupt and clock-output control of a stand-alone can controller
// Functional notes
// - enable bit7 message error, bit6 bus wake, bit5 error-flag change.
// - enable bits 4,3,2 arm transmit buffer 2,1,0 empty interrupts.
// - enable bits 1,0 arm receive buffer 1,0 full interrupts.
// - flags reset to 0, stay set until host clears them.
// - start-up timer holds logic reset 128 cycles after reset and wake.
// - clock output divides by 1, 2, 4 or 8, enabled from control; the code gives periods of 2, 4, 8 or 16 cycles.
// - after reset clock output runs, divided by 8; the code runs it at a 16-cycle period.
// - sixteen more output cycles before sleep, then output held low.
// - clock output enable cleared puts the pin in high impedance.
// - enable or divider changes never shorten an output phase.
// - mode change waits for pending transmissions; host reads status.
// - configuration after reset or on code 100, clearing error counters.
// - timing, send-request and filter writes allowed only in configuration.
// - in sleep, register reads keep working.
// - sleep stops oscillator; wake on bus activity or host-set wake flag.
// - transmit output recessive throughout sleep.
// - after wake discard traffic, enter listen-only; host requests normal.
// - a control bit enables a glitch filter on receive during sleep.
// - listen-only transmits nothing, error counters held reset.
// - loopback routes internally, ignores ack, transmit output recessive.
// - only normal mode transmits, acknowledges and sends error frames.
// - mode codes 000 normal 001 sleep 010 loopback 011 listen 100 config.
// - divider codes 00 by 1, 01 by 2, 10 by 4, 11 by 8; the code divides by 2, 4, 8, 16.
// - interrupt output low while any enabled flag is set.
// - source code shows most urgent enabled pending source, 000 none; a message error alone also reads 000.
`timescale 1ns/10ps
`default_nettype none
module ccm_top #(
  parameter int OST_LEN = ccm_pkg::OST_CYCLES,
  parameter int FILT_LEN = ccm_pkg::WAKE_FILT_CYCLES,
  parameter int IDLE_LEN = ccm_pkg::IDLE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_wmask_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire ccm_pkg::ccm_evt_s evt_i,
  input wire logic tx_pending_i,
  input wire logic wake_glitch_filter_en_i,
  input wire logic core_tx_i,
  input wire logic bus_receive_input_i,
  output logic bus_transmit_output_o,
  output ccm_pkg::ccm_mode_ctl_s mode_ctl_o,
  output logic cfg_wr_allow_o,
  output logic core_hold_o,
  output logic osc_run_o,
  output logic irq_n_o,
  output logic divided_clock_output_o,
  output logic divided_clock_output_oe_o
);
  import ccm_pkg::*;

  ccm_state_e state_reg, state_next;
  logic [7:0] interrupt_enable_reg;
  logic [7:0] interrupt_flags_reg, interrupt_flags_next;
  logic [7:0] main_control_reg, main_control_next;
  logic [2:0] mode_code_reg, mode_code_next;
  logic [7:0] ost_cnt_reg;
  logic [4:0] drain_cnt_reg;
  logic [3:0] filt_cnt_reg;
  logic [3:0] idle_cnt_reg;
  logic discard_reg;
  logic rx_s1_reg, rx_s2_reg;

  ///////////////////////////////////////////////////////////////////////
  // register decode
  logic hold;
  logic wr_ok;
  logic wr_ie, wr_if, wr_ctl;
  logic rd_ie, rd_if, rd_sts, rd_ctl;
  assign hold = (ost_cnt_reg != 8'h00);
  assign wr_ok = reg_wr_i & ~hold;
  assign wr_ie = wr_ok & (reg_addr_i == ADDR_IRQ_EN);
  assign wr_if = wr_ok & (reg_addr_i == ADDR_IRQ_FLAGS);
  assign wr_ctl = wr_ok & (reg_addr_i[3:0] == ADDR_LO_CONTROL);
  assign rd_ie = reg_addr_i == ADDR_IRQ_EN;
  assign rd_if = reg_addr_i == ADDR_IRQ_FLAGS;
  assign rd_sts = reg_addr_i[3:0] == ADDR_LO_STATUS;
  assign rd_ctl = reg_addr_i[3:0] == ADDR_LO_CONTROL;

  // bit-modify merge: masked bits take the written value
  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [7:0] val,
                                       input logic [7:0] msk);
    merge = (old & ~msk) | (val & msk);
  endfunction

  ///////////////////////////////////////////////////////////////////////
  // receive pin synchroniser and sleep wake detector
  logic filt_full;
  logic bus_activity;
  logic wake_set;
  assign filt_full = filt_cnt_reg == 4'(FILT_LEN - 1);
  assign bus_activity = (state_reg == ST_SLEEP) & ~rx_s2_reg &
                        (~wake_glitch_filter_en_i | filt_full);
  assign wake_set = bus_activity & interrupt_enable_reg[BIT_WAKE];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
    end else begin
      rx_s1_reg <= bus_receive_input_i;
      rx_s2_reg <= rx_s1_reg;
    end
  end

  // low-pass: dominant must persist before it counts as activity
  always_ff @(posedge clk_i) begin
    if (rst_i || rx_s2_reg || state_reg != ST_SLEEP) begin
      filt_cnt_reg <= 4'h0;
    end else if (!filt_full) begin
      filt_cnt_reg <= filt_cnt_reg + 4'h1;
    end
  end

  ///////////////////////////////////////////////////////////////////////
  // interrupt flags, enables and source code
  logic [7:0] hw_set;
  logic [7:0] active;
  logic [2:0] irq_source_code;
  assign hw_set = {evt_i.msg_error, wake_set, evt_i.err_change,
                   evt_i.tx_buf2_empty, evt_i.tx_buf1_empty,
                   evt_i.tx_buf0_empty, evt_i.rx_buf1_full,
                   evt_i.rx_buf0_full};
  assign active = interrupt_flags_reg & interrupt_enable_reg;
  // host write first, hardware set or'ed after so it cannot be lost
  assign interrupt_flags_next = (wr_if ? merge(interrupt_flags_reg,
      reg_wdata_i, reg_wmask_i) : interrupt_flags_reg) | hw_set;
  assign irq_source_code = active[BIT_ERR_CHG] ? IRQ_SOURCE_CODE_ERR :
                active[BIT_WAKE] ? IRQ_SOURCE_CODE_WAKE :
                active[BIT_TX0] ? IRQ_SOURCE_CODE_TX0 :
                active[BIT_TX1] ? IRQ_SOURCE_CODE_TX1 :
                active[BIT_TX2] ? IRQ_SOURCE_CODE_TX2 :
                active[BIT_RX0] ? IRQ_SOURCE_CODE_RX0 :
                active[BIT_RX1] ? IRQ_SOURCE_CODE_RX1 : IRQ_SOURCE_CODE_NONE;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      interrupt_enable_reg <= RST_IRQ_EN;
      interrupt_flags_reg <= RST_IRQ_FLAGS;
      irq_n_o <= 1'b1;
    end else begin
      if (wr_ie) begin
        interrupt_enable_reg <= merge(interrupt_enable_reg, reg_wdata_i,
                                      reg_wmask_i);
      end
      interrupt_flags_reg <= interrupt_flags_next;
      irq_n_o <= ~|(interrupt_flags_next & interrupt_enable_reg);
    end
  end

  ///////////////////////////////////////////////////////////////////////
  // control register and mode state machine
  logic [2:0] req;
  logic req_valid;
  logic drain_done;
  logic wake_go;
  logic clk_period;
  assign main_control_next = wr_ctl ? merge(main_control_reg, reg_wdata_i,
                                            reg_wmask_i) : main_control_reg;
  assign req = main_control_reg[CTL_REQ_LSB +: 3];
  assign req_valid = (req <= MODE_CONFIG) && (req != mode_code_reg) &&
                     !tx_pending_i && !hold;
  assign drain_done = drain_cnt_reg == 5'(SLEEP_CLK_PERIODS);
  // host may set the wake flag itself; the enable still gates it
  assign wake_go = interrupt_flags_reg[BIT_WAKE] &
                   interrupt_enable_reg[BIT_WAKE];

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_DRAIN: begin
        if (drain_done && clk_period) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_go) begin
          state_next = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (!hold) begin
          state_next = ST_LISTEN;
        end
      end
      default: begin
        if (req_valid) begin
          case (req)
            MODE_NORMAL: state_next = ST_NORMAL;
            MODE_SLEEP: state_next = ST_DRAIN;
            MODE_LOOPBACK: state_next = ST_LOOP;
            MODE_LISTEN: state_next = ST_LISTEN;
            default: state_next = ST_CONFIG;
          endcase
        end
      end
    endcase
  end

  // status follows the settled mode; drain and wake keep the old code
  always_comb begin
    mode_code_next = mode_code_reg;
    case (state_next)
      ST_CONFIG: mode_code_next = MODE_CONFIG;
      ST_NORMAL: mode_code_next = MODE_NORMAL;
      ST_SLEEP: mode_code_next = MODE_SLEEP;
      ST_LISTEN: mode_code_next = MODE_LISTEN;
      ST_LOOP: mode_code_next = MODE_LOOPBACK;
      default: mode_code_next = mode_code_reg;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_CONFIG;
      mode_code_reg <= MODE_CONFIG;
      main_control_reg <= RST_CONTROL;
    end else begin
      state_reg <= state_next;
      mode_code_reg <= mode_code_next;
      main_control_reg <= main_control_next;
    end
  end

  // start-up hold-off, restarted on every wake
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ost_cnt_reg <= 8'(OST_LEN);
    end else if (state_reg == ST_SLEEP && wake_go) begin
      ost_cnt_reg <= 8'(OST_LEN);
    end else if (hold) begin
      ost_cnt_reg <= ost_cnt_reg - 8'h01;
    end
  end

  // counts clock-output rising edges before sleep; the next one is withheld
  always_ff @(posedge clk_i) begin
    if (rst_i || state_reg != ST_DRAIN) begin
      drain_cnt_reg <= 5'h00;
    end else if (clk_period && !drain_done) begin
      drain_cnt_reg <= drain_cnt_reg + 5'h01;
    end
  end

  // drop traffic until the bus has been idle after waking
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      discard_reg <= 1'b0;
      idle_cnt_reg <= 4'h0;
    end else if (state_reg == ST_WAKE || state_reg == ST_SLEEP) begin
      discard_reg <= state_reg == ST_WAKE;
      idle_cnt_reg <= 4'h0;
    end else if (!rx_s2_reg) begin
      idle_cnt_reg <= 4'h0;
    end else if (idle_cnt_reg == 4'(IDLE_LEN - 1)) begin
      discard_reg <= 1'b0;
    end else begin
      idle_cnt_reg <= idle_cnt_reg + 4'h1;
    end
  end

  ///////////////////////////////////////////////////////////////////////
  // mode outputs and register read port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_transmit_output_o <= 1'b1;
      mode_ctl_o <= '0;
      cfg_wr_allow_o <= 1'b0;
      core_hold_o <= 1'b1;
      osc_run_o <= 1'b1;
      reg_rdata_o <= 8'h00;
    end else begin
      // only normal mode drives the bus; all others stay recessive
      bus_transmit_output_o <= (state_next == ST_NORMAL) ? core_tx_i
                                                         : 1'b1;
      mode_ctl_o.tx_allowed <= state_next == ST_NORMAL;
      mode_ctl_o.listen_only <= state_next == ST_LISTEN;
      mode_ctl_o.loopback <= state_next == ST_LOOP;
      mode_ctl_o.err_cnt_clear <= state_next == ST_CONFIG ||
                                  state_next == ST_LISTEN;
      mode_ctl_o.rx_discard <= discard_reg;
      cfg_wr_allow_o <= state_next == ST_CONFIG;
      core_hold_o <= (ost_cnt_reg > 8'h01) || wake_go &&
                     state_reg == ST_SLEEP;
      osc_run_o <= state_next != ST_SLEEP;
      // reads stay served in every mode, sleep included
      if (reg_rd_i) begin
        if (rd_ie) begin
          reg_rdata_o <= interrupt_enable_reg;
        end else if (rd_if) begin
          reg_rdata_o <= interrupt_flags_reg;
        end else if (rd_sts) begin
          reg_rdata_o <= {mode_code_reg, 1'b0, irq_source_code, 1'b0};
        end else if (rd_ctl) begin
          reg_rdata_o <= main_control_reg;
        end else begin
          reg_rdata_o <= 8'h00;
        end
      end
    end
  end

  ccm_divided_clock_output u_divided_clock_output (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(main_control_reg[CTL_CLOCK_OUTPUT_EN]),
    .div_i(main_control_reg[CTL_DIV_LSB +: 2]),
    .stop_i(state_reg == ST_SLEEP || (state_reg == ST_DRAIN && drain_done)),
    .clk_o(divided_clock_output_o),
    .clk_oe_o(divided_clock_output_oe_o),
    .period_o(clk_period)
  );

  ///////////////////////////////////////////////////////////////////////
  // checks
  logic [7:0] hold_len_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i || !hold) begin
      hold_len_reg <= 8'h00;
    end else begin
      hold_len_reg <= hold_len_reg + 8'h01;
    end
  end

  property p_ost_len;
    @(posedge clk_i) disable iff (rst_i)
      $fell(hold) |-> $past(hold_len_reg) == 8'(OST_LEN - 1);
  endproperty
  a_ost_len: assert property (p_ost_len) else $error("holdoff length");

  property p_flag_sticky;
    @(posedge clk_i) disable iff (rst_i)
      interrupt_flags_reg[BIT_TX0] && !wr_if |=> interrupt_flags_reg[BIT_TX0];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

  property p_set_wins;
    @(posedge clk_i) disable iff (rst_i)
      evt_i.rx_buf0_full && wr_if && reg_wmask_i[BIT_RX0] &&
      !reg_wdata_i[BIT_RX0] |=> interrupt_flags_reg[BIT_RX0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat set");

  property p_irq_out;
    @(posedge clk_i) disable iff (rst_i)
      |active ##1 |active |-> !irq_n_o;
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("irq not low");

  property p_quiet_tx;
    @(posedge clk_i) disable iff (rst_i)
      state_reg != ST_NORMAL && state_next != ST_NORMAL |=>
        bus_transmit_output_o;
  endproperty
  a_quiet_tx: assert property (p_quiet_tx) else $error("tx not recessive");

  property p_mode_waits;
    @(posedge clk_i) disable iff (rst_i)
      tx_pending_i && !(state_reg inside {ST_DRAIN, ST_SLEEP, ST_WAKE})
        |=> $stable(mode_code_reg);
  endproperty
  a_mode_waits: assert property (p_mode_waits) else $error("early mode");

  property p_wake_listen;
    @(posedge clk_i) disable iff (rst_i)
      $rose(state_reg == ST_WAKE) |-> ##[1:300] mode_code_reg == MODE_LISTEN;
  endproperty
  a_wake_listen: assert property (p_wake_listen) else $error("no listen");

  property p_irq_source_code_err;
    @(posedge clk_i) disable iff (rst_i)
      active[BIT_ERR_CHG] |-> irq_source_code == IRQ_SOURCE_CODE_ERR;
  endproperty
  a_irq_source_code_err: assert property (p_irq_source_code_err) else $error("irq_source_code order");

  property p_sleep_low;
    @(posedge clk_i) disable iff (rst_i)
      state_reg == ST_SLEEP ##1 state_reg == ST_SLEEP |->
        !divided_clock_output_o;
  endproperty
  a_sleep_low: assert property (p_sleep_low) else $error("clk in sleep");

  c_sleep: cover property (@(posedge clk_i) state_reg == ST_SLEEP);
  c_wake: cover property (@(posedge clk_i) state_reg == ST_WAKE);
  c_loop: cover property (@(posedge clk_i) state_reg == ST_LOOP);
endmodule
`default_nettype wire

/* File: tb/ccm_bus_model.sv */
// can bus model: our transmitter wired-and with one remote node
`timescale 1ns/10ps
`default_nettype none
module ccm_bus_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tx_i,
  input wire logic go_i,
  input wire logic [7:0] len_i,
  output logic rx_o
);
  logic [7:0] cnt_reg;
  // remote node holds the bus dominant for len_i cycles after go_i
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 8'h00;
    end else if (go_i) begin
      cnt_reg <= len_i;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end
  // dominant wins, so a silent node still hears the remote one
  assign rx_o = tx_i & (cnt_reg == 8'h00);
endmodule
`default_nettype wire

/* File: tb/ccm_top_tb.sv */
// self-checking bench for the mode, interrupt and clock-out block
`timescale 1ns/10ps
`default_nettype none
module ccm_top_tb;
  import ccm_pkg::*;
  localparam int OSC_STARTUP_HOLDOFF = 8;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, txp = 1'b0;
  logic ctx = 1'b1, wfe = 1'b0, go = 1'b0;
  logic [7:0] blen = 8'h01, addr = 8'h00, wdata = 8'h00, wmask = 8'h00;
  logic [7:0] rdata;
  logic rxb, txo, cwa, hold, orun, irqn, ck, ckoe;
  ccm_evt_s evt = '0;
  ccm_mode_ctl_s mctl;
  int miscompares = 0, n_tests = 0, ncl = 0;
  ccm_top #(.OST_LEN(OSC_STARTUP_HOLDOFF), .FILT_LEN(2), .IDLE_LEN(2)) u_dut (
    .clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wmask_i(wmask), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .evt_i(evt), .tx_pending_i(txp), .wake_glitch_filter_en_i(wfe),
    .core_tx_i(ctx), .bus_receive_input_i(rxb), .bus_transmit_output_o(txo),
    .mode_ctl_o(mctl), .cfg_wr_allow_o(cwa), .core_hold_o(hold),
    .osc_run_o(orun), .irq_n_o(irqn), .divided_clock_output_o(ck),
    .divided_clock_output_oe_o(ckoe));
  ccm_bus_model u_bus (.clk_i(clk), .rst_i(rst), .tx_i(txo), .go_i(go),
    .len_i(blen), .rx_o(rxb));
  // 10 mhz oscillator and clock-out edge count
  always #50 clk = ~clk;
  always @(posedge ck) ncl++;
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(string w, logic [7:0] s, logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic cb(string w, logic s, logic e);
    check(w, {7'h00, s}, {7'h00, e});
  endtask
  // inputs move 1 ns after the edge, so no race with the design
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(logic [7:0] a, logic [7:0] d, logic [7:0] m);
    addr = a;
    wdata = d;
    wmask = m;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
    tick(1);
  endtask
  task automatic chk_reg(logic [7:0] a, logic [7:0] e, string w);
    addr = a;
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    tick(1);
    check(w, rdata, e);
  endtask
  task automatic ctrl(logic [2:0] m);
    wr_reg(8'h0F, {m, 5'h07}, 8'hFF);
  endtask
  task automatic pulse(ccm_evt_s e);
    evt = e;
    tick(1);
    evt = '0;
    tick(1);
  endtask
  task automatic wait_ck(logic v, output int n);
    n = 0;
    while (ck !== v && n < 99) begin
      tick(1);
      n++;
    end
  endtask
  // length of the next complete high phase in clock cycles
  task automatic hi_len(output int n);
    wait_ck(1'b0, n);
    wait_ck(1'b1, n);
    wait_ck(1'b0, n);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    int n;
    cb("hold", hold, 1'b1);
    wr_reg(ADDR_IRQ_EN, 8'hFF, 8'hFF);
    tick(OSC_STARTUP_HOLDOFF);
    cb("hold", hold, 1'b0);
    chk_reg(ADDR_IRQ_EN, 8'h00, "enables");
    chk_reg(ADDR_IRQ_FLAGS, 8'h00, "flags");
    chk_reg(8'h1E, 8'h80, "status");
    chk_reg(8'h5F, 8'hE7, "control");
    chk_reg(8'h00, 8'h00, "unmapped");
    hi_len(n);
    check("phase", 8'(n), 8'h08);
  endtask
  task automatic t_clk();
    int n;
    for (int d = 0; d < 4; d++) begin
      wr_reg(8'h0F, 8'h84 | 8'(d), 8'hFF);
      hi_len(n);
      hi_len(n);
      check("phase", 8'(n), 8'h01 << d);
    end
    wr_reg(8'h0F, 8'h80, 8'hFF);
    tick(30);
    cb("oe off", ckoe, 1'b0);
    wr_reg(8'h0F, 8'h87, 8'hFF);
    tick(30);
    cb("oe on", ckoe, 1'b1);
  endtask
  task automatic t_irq();
    int fb;
    logic [20:0] ic = {3'h0, 3'h1, 3'h5, 3'h4, 3'h3, 3'h7, 3'h6};
    wr_reg(ADDR_IRQ_EN, 8'hFF, 8'hFF);
    for (int j = 0; j < 7; j++) begin
      fb = (j == 6) ? 7 : j;
      pulse(ccm_evt_s'(7'h01 << j));
      chk_reg(ADDR_IRQ_FLAGS, 8'h01 << fb, "flag");
      cb("irq_n", irqn, 1'b0);
      chk_reg(8'h3E, {4'h8, ic[3*j +: 3], 1'b0}, "code");
      wr_reg(ADDR_IRQ_FLAGS, 8'h00, 8'h01 << fb);
      cb("irq_n", irqn, 1'b1);
    end
    pulse(ccm_evt_s'(7'h11));
    chk_reg(8'h0E, {4'h8, IRQ_SOURCE_CODE_TX2, 1'b0}, "code");
    wr_reg(ADDR_IRQ_FLAGS, 8'h00, 8'h10);
    chk_reg(8'h0E, {4'h8, IRQ_SOURCE_CODE_RX0, 1'b0}, "code");
    wr_reg(ADDR_IRQ_FLAGS, 8'h00, 8'hFF);
    wr_reg(ADDR_IRQ_EN, 8'h00, 8'h04);
    pulse(ccm_evt_s'(7'h04));
    chk_reg(ADDR_IRQ_FLAGS, 8'h04, "flag");
    cb("irq_n", irqn, 1'b1);
    wr_reg(ADDR_IRQ_EN, 8'hFF, 8'hFF);
    addr = ADDR_IRQ_FLAGS;
    wdata = 8'h00;
    wmask = 8'h04;
    wr = 1'b1;
    evt = ccm_evt_s'(7'h04);
    tick(1);
    wr = 1'b0;
    evt = '0;
    tick(1);
    chk_reg(ADDR_IRQ_FLAGS, 8'h04, "set wins");
    wr_reg(ADDR_IRQ_FLAGS, 8'h00, 8'hFF);
  endtask
  task automatic t_mode();
    logic [2:0] mc [4] = '{MODE_NORMAL, MODE_LOOPBACK, MODE_LISTEN, MODE_CONFIG};
    logic [3:0] xc [4] = '{4'h8, 4'h2, 4'h5, 4'h1};
    ctx = 1'b0;
    for (int i = 0; i < 4; i++) begin
      ctrl(mc[i]);
      chk_reg(8'h0E, {mc[i], 5'h00}, "mode");
      check("ctl", 8'({mctl.tx_allowed, mctl.listen_only, mctl.loopback,
        mctl.err_cnt_clear}), 8'(xc[i]));
      cb("tx", txo, i != 0);
      cb("cfg", cwa, i == 3);
    end
    txp = 1'b1;
    ctrl(MODE_NORMAL);
    tick(8);
    chk_reg(8'h0E, 8'h80, "pending");
    txp = 1'b0;
    tick(2);
    chk_reg(8'h0E, 8'h00, "mode");
    ctrl(3'h6);
    chk_reg(8'h0E, 8'h00, "invalid");
  endtask
  task automatic t_sleep();
    int n, c;
    wr_reg(ADDR_IRQ_EN, 8'h40, 8'hFF);
    wfe = 1'b1;
    c = ncl;
    ctrl(MODE_SLEEP);
    wait_ck(1'b0, n);
    n = 0;
    while (orun !== 1'b0 && n < 999) begin
      tick(1);
      n++;
    end
    // count may include the period running when the request landed
    cb("sixteen", ncl - c > 15 && ncl - c < 18, 1'b1);
    tick(20);
    cb("ck low", ck, 1'b0);
    cb("tx", txo, 1'b1);
    chk_reg(8'h0E, {MODE_SLEEP, 5'h00}, "asleep");
    go = 1'b1;
    tick(1);
    go = 1'b0;
    tick(10);
    cb("glitch", orun, 1'b0);
    blen = 8'h10;
    go = 1'b1;
    tick(1);
    go = 1'b0;
    tick(12);
    cb("discard", mctl.rx_discard, 1'b1);
    tick(8);
    cb("wake", orun, 1'b1);
    tick(OSC_STARTUP_HOLDOFF + 20);
    chk_reg(8'h0E, {MODE_LISTEN, 1'b0, IRQ_SOURCE_CODE_WAKE, 1'b0}, "woken");
    cb("irq_n", irqn, 1'b0);
    cb("tx", txo, 1'b1);
    cb("kept", mctl.rx_discard, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(4);
    rst = 1'b0;
    t_reset();
    t_clk();
    t_irq();
    t_mode();
    t_sleep();
    wrap_up();
  end
  // hang guard, well beyond the fewer than a thousand cycles the run needs
  initial begin
    #(30000 * 100);
    miscompares++;
    wrap_up();
  end
endmodule
`default_nettype wire
